// file: src/pam_pkg.sv
/*
 pam_pkg: register indices, implemented-bit masks, reset values, pin
 positions, function-select codes and peripheral signal bundles for the
 port alternate-function multiplexer.
 Assumes a word-addressed Avalon-MM slave port with 32-bit data.
*/
package pam_pkg;
  // register indices; each index is one 32-bit bus word
  localparam logic [31:0] IDX_P9_MODE = 32'hFFFFF452;
  localparam logic [31:0] IDX_P9_FSEL = 32'hFFFFF472;
  localparam logic [31:0] IDX_P9_FEXT = 32'hFFFFF712;
  localparam logic [31:0] IDX_P9_OD = 32'h0FFFFC72;
  localparam logic [31:0] IDX_BUS_MODE = 32'hFFFFF04C;
  localparam logic [31:0] IDX_STB_MODE = 32'hFFFFF04A;
  localparam logic [31:0] IDX_HI_STEP = 32'h00000001;
  // implemented bits
  localparam logic [15:0] P9_MASK = 16'hE3C3;
  localparam logic [15:0] P9_EXT_MASK = 16'hC0C3;
  localparam logic [7:0] BUS_MASK = 8'h0F;
  localparam logic [7:0] STB_MASK = 8'h53;
  localparam logic [15:0] RST16 = 16'h0000;
  localparam logic [7:0] RST8 = 8'h00;
  // {extended, function-select} codes
  localparam logic [1:0] SEL_NONE = 2'b00;
  localparam logic [1:0] SEL_A = 2'b01;
  localparam logic [1:0] SEL_B = 2'b10;
  localparam logic [1:0] SEL_C = 2'b11;
  // port 9 pin positions
  localparam int PIN_IRQ6 = 15;
  localparam int PIN_IRQ5 = 14;
  localparam int PIN_IRQ4 = 13;
  localparam int PIN_SCK = 9;
  localparam int PIN_SO = 8;
  localparam int PIN_SI = 7;
  localparam int PIN_TP21 = 6;
  localparam int PIN_RX = 1;
  localparam int PIN_TX = 0;
  // bus-control and strobe port positions
  localparam int CM_WAIT = 0;
  localparam int CM_CLK = 1;
  localparam int CM_HACK = 2;
  localparam int CM_HREQ = 3;
  localparam int CT_WRL = 0;
  localparam int CT_WRH = 1;
  localparam int CT_RD = 4;
  localparam int CT_ADDRESS_STROBE_OUT = 6;

  // signals that peripherals send toward the pins
  typedef struct packed {
    logic timer_p5_out_0;
    logic timer_p5_out_1;
    logic timer_p2_out_0;
    logic timer_p2_out_1;
    logic csi1_data_out;
    logic csi1_clock_out;
    logic csi1_clock_oe;
    logic async1_transmit_out;
    logic hold_acknowledge_out;
    logic clock_output;
    logic address_strobe_out;
    logic read_strobe_out;
    logic write_strobe_low;
    logic write_strobe_high;
  } pam_to_pin_s;

  // pin levels handed to peripherals
  typedef struct packed {
    logic ext_irq_in_4;
    logic ext_irq_in_5;
    logic ext_irq_in_6;
    logic timer_p5_capture_in_0;
    logic timer_p5_capture_in_1;
    logic timer_p2_capture_in_0;
    logic timer_p2_capture_in_1;
    logic csi1_data_in;
    logic csi1_clock_in;
    logic key_return_in_6;
    logic key_return_in_7;
    logic async1_receive_in;
    logic hold_request_in;
    logic wait_in;
  } pam_from_pin_s;
endpackage

// file: src/pam_pin_cell.sv
/*
 pam_pin_cell: output stage of one pin; picks port or alternate drive
 and applies open-drain conversion, then registers level and enable.
 Assumes the caller resolves the wire level from o_pin and o_pin_oe.
*/
`timescale 1ns/1ps
module pam_pin_cell (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // selection
  input wire logic i_mode,
  input wire logic i_od,
  // drive sources
  input wire logic i_alt_o,
  input wire logic i_alt_oe,
  input wire logic i_port_o,
  input wire logic i_port_oe,
  // pin
  output logic o_pin,
  output logic o_pin_oe
);
  logic pin_d;
  logic oe_d;
  logic src_o;
  logic src_oe;

  always_comb begin
    src_o = i_mode ? i_alt_o : i_port_o;
    src_oe = i_mode ? i_alt_oe : i_port_oe;
    pin_d = src_o;
    oe_d = src_oe;
    // open drain: only pull low, release for a high
    if (i_od) begin
      pin_d = 1'b0;
      oe_d = src_oe & ~src_o;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pin <= 1'b0;
      o_pin_oe <= 1'b0;
    end else begin
      o_pin <= pin_d;
      o_pin_oe <= oe_d;
    end
  end
endmodule

// file: src/pam_port_mux.sv
/*
 pam_port_mux: alternate-function multiplexer for port 9, the bus
 control port and the strobe port, with its Avalon-MM register slave.
 Assumes port data and direction come from a separate port block and
 that pins are resolved outside from level and enable pairs.
*/
`timescale 1ns/1ps
module pam_port_mux (
  // clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  // Avalon-MM slave, word addressed
  input wire logic [31:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // port-mode drive from the port data and direction block
  input wire logic [15:0] I_P9_PORT_OUT,
  input wire logic [15:0] I_P9_PORT_OE,
  input wire logic [3:0] I_CM_PORT_OUT,
  input wire logic [3:0] I_CM_PORT_OE,
  input wire logic [7:0] I_CT_PORT_OUT,
  input wire logic [7:0] I_CT_PORT_OE,
  // peripherals
  input wire pam_pkg::pam_to_pin_s I_PERIPH,
  output pam_pkg::pam_from_pin_s O_PERIPH,
  // pins
  input wire logic [15:0] I_P9_PIN,
  output logic [15:0] O_P9_PIN,
  output logic [15:0] O_P9_PIN_OE,
  input wire logic [3:0] I_CM_PIN,
  output logic [3:0] O_CM_PIN,
  output logic [3:0] O_CM_PIN_OE,
  input wire logic [7:0] I_CT_PIN,
  output logic [7:0] O_CT_PIN,
  output logic [7:0] O_CT_PIN_OE,
  // synchronised pin levels for port reads
  output logic [15:0] O_P9_LEVEL,
  output logic [3:0] O_CM_LEVEL,
  output logic [7:0] O_CT_LEVEL
);
  // merge a bus write into a 16-bit register seen as word or halves
  function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [15:0] msk, input logic hi, input logic [3:0] be,
      input logic [31:0] wd);
    logic [15:0] n;
    n = old;
    if (hi) begin
      if (be[0]) n[15:8] = wd[7:0];
    end else begin
      if (be[0]) n[7:0] = wd[7:0];
      if (be[1]) n[15:8] = wd[15:8];
    end
    return n & msk;
  endfunction

  function automatic logic [31:0] read16(input logic [15:0] v,
      input logic hi);
    return hi ? {24'h000000, v[15:8]} : {16'h0000, v};
  endfunction

  function automatic logic hit16(input logic [31:0] adr,
      input logic [31:0] base);
    return adr == base || adr == base + pam_pkg::IDX_HI_STEP;
  endfunction

  logic [15:0] mode_q, mode_d;
  logic [15:0] fsel_q, fsel_d;
  logic [15:0] fext_q, fext_d;
  logic [15:0] od_q, od_d;
  logic [7:0] bus_q, bus_d;
  logic [7:0] stb_q, stb_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [15:0] p9_s1_q, p9_s2_q;
  logic [3:0] cm_s1_q, cm_s2_q;
  logic [7:0] ct_s1_q, ct_s2_q;
  logic req, acc;
  logic [31:0] rd_val, a;

  assign req = I_AVS_READ | I_AVS_WRITE;
  // one wait cycle lets read data come from a register
  assign O_AVS_WAITREQUEST = req & ~ack_q;
  assign acc = req & ack_q;
  assign O_AVS_READDATA = rdata_q;
  assign a = I_AVS_ADDRESS;
  assign O_P9_LEVEL = p9_s2_q;
  assign O_CM_LEVEL = cm_s2_q;
  assign O_CT_LEVEL = ct_s2_q;

  // read decode; unmapped words read as zero
  always_comb begin
    rd_val = 32'h00000000;
    if (hit16(a, pam_pkg::IDX_P9_MODE)) begin
      rd_val = read16(mode_q, a != pam_pkg::IDX_P9_MODE);
    end else if (hit16(a, pam_pkg::IDX_P9_FSEL)) begin
      rd_val = read16(fsel_q, a != pam_pkg::IDX_P9_FSEL);
    end else if (hit16(a, pam_pkg::IDX_P9_FEXT)) begin
      rd_val = read16(fext_q, a != pam_pkg::IDX_P9_FEXT);
    end else if (hit16(a, pam_pkg::IDX_P9_OD)) begin
      rd_val = read16(od_q, a != pam_pkg::IDX_P9_OD);
    end else if (a == pam_pkg::IDX_BUS_MODE) begin
      rd_val = {24'h000000, bus_q};
    end else if (a == pam_pkg::IDX_STB_MODE) begin
      rd_val = {24'h000000, stb_q};
    end
  end

  // register writes take effect at the edge where waitrequest is low
  always_comb begin
    mode_d = mode_q;
    fsel_d = fsel_q;
    fext_d = fext_q;
    od_d = od_q;
    bus_d = bus_q;
    stb_d = stb_q;
    ack_d = req & ~ack_q;
    rdata_d = (req & ~ack_q) ? rd_val : rdata_q;
    if (acc && I_AVS_WRITE) begin
      if (hit16(a, pam_pkg::IDX_P9_MODE)) begin
        mode_d = merge16(mode_q, pam_pkg::P9_MASK,
          a != pam_pkg::IDX_P9_MODE, I_AVS_BYTEENABLE, I_AVS_WRITEDATA);
      end
      if (hit16(a, pam_pkg::IDX_P9_FSEL)) begin
        fsel_d = merge16(fsel_q, pam_pkg::P9_MASK,
          a != pam_pkg::IDX_P9_FSEL, I_AVS_BYTEENABLE, I_AVS_WRITEDATA);
      end
      if (hit16(a, pam_pkg::IDX_P9_FEXT)) begin
        fext_d = merge16(fext_q, pam_pkg::P9_EXT_MASK,
          a != pam_pkg::IDX_P9_FEXT, I_AVS_BYTEENABLE, I_AVS_WRITEDATA);
      end
      if (hit16(a, pam_pkg::IDX_P9_OD)) begin
        od_d = merge16(od_q, pam_pkg::P9_MASK,
          a != pam_pkg::IDX_P9_OD, I_AVS_BYTEENABLE, I_AVS_WRITEDATA);
      end
      if (a == pam_pkg::IDX_BUS_MODE && I_AVS_BYTEENABLE[0]) begin
        bus_d = I_AVS_WRITEDATA[7:0] & pam_pkg::BUS_MASK;
      end
      if (a == pam_pkg::IDX_STB_MODE && I_AVS_BYTEENABLE[0]) begin
        stb_d = I_AVS_WRITEDATA[7:0] & pam_pkg::STB_MASK;
      end
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      mode_q <= pam_pkg::RST16;
      fsel_q <= pam_pkg::RST16;
      fext_q <= pam_pkg::RST16;
      od_q <= pam_pkg::RST16;
      bus_q <= pam_pkg::RST8;
      stb_q <= pam_pkg::RST8;
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      mode_q <= mode_d;
      fsel_q <= fsel_d;
      fext_q <= fext_d;
      od_q <= od_d;
      bus_q <= bus_d;
      stb_q <= stb_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // pin input synchronisers
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      p9_s1_q <= 16'h0000;
      p9_s2_q <= 16'h0000;
      cm_s1_q <= 4'h0;
      cm_s2_q <= 4'h0;
      ct_s1_q <= 8'h00;
      ct_s2_q <= 8'h00;
    end else begin
      p9_s1_q <= I_P9_PIN;
      p9_s2_q <= p9_s1_q;
      cm_s1_q <= I_CM_PIN;
      cm_s2_q <= cm_s1_q;
      ct_s1_q <= I_CT_PIN;
      ct_s2_q <= ct_s1_q;
    end
  end

  // port 9 function decode
  logic [15:0] p9_alt_o, p9_alt_oe;
  logic [3:0] cm_alt_o, cm_alt_oe;
  logic [7:0] ct_alt_o, ct_alt_oe;
  logic [1:0] pr15, pr14, pr7, pr6, pr1, pr0;
  logic [15:0] on, lv;

  always_comb begin
    on = mode_q;
    lv = p9_s2_q;
    pr15 = {fext_q[pam_pkg::PIN_IRQ6], fsel_q[pam_pkg::PIN_IRQ6]};
    pr14 = {fext_q[pam_pkg::PIN_IRQ5], fsel_q[pam_pkg::PIN_IRQ5]};
    pr7 = {fext_q[pam_pkg::PIN_SI], fsel_q[pam_pkg::PIN_SI]};
    pr6 = {fext_q[pam_pkg::PIN_TP21], fsel_q[pam_pkg::PIN_TP21]};
    pr1 = {fext_q[pam_pkg::PIN_RX], fsel_q[pam_pkg::PIN_RX]};
    pr0 = {fext_q[pam_pkg::PIN_TX], fsel_q[pam_pkg::PIN_TX]};
    // a prohibited pair leaves the pin undriven and feeds nothing
    p9_alt_o = 16'h0000;
    p9_alt_oe = 16'h0000;
    O_PERIPH = '0;
    O_PERIPH.ext_irq_in_6 = on[15] & (pr15 == pam_pkg::SEL_A) & lv[15];
    O_PERIPH.timer_p5_capture_in_0 = on[15] &
      (pr15 == pam_pkg::SEL_B) & lv[15];
    p9_alt_oe[15] = pr15 == pam_pkg::SEL_C;
    p9_alt_o[15] = I_PERIPH.timer_p5_out_0;
    O_PERIPH.ext_irq_in_5 = on[14] & (pr14 == pam_pkg::SEL_A) & lv[14];
    O_PERIPH.timer_p5_capture_in_1 = on[14] &
      (pr14 == pam_pkg::SEL_B) & lv[14];
    p9_alt_oe[14] = pr14 == pam_pkg::SEL_C;
    p9_alt_o[14] = I_PERIPH.timer_p5_out_1;
    O_PERIPH.ext_irq_in_4 = on[13] & fsel_q[13] & lv[13];
    O_PERIPH.csi1_clock_in = on[9] & fsel_q[9] & lv[9];
    p9_alt_oe[9] = fsel_q[9] & I_PERIPH.csi1_clock_oe;
    p9_alt_o[9] = I_PERIPH.csi1_clock_out;
    p9_alt_oe[8] = fsel_q[8];
    p9_alt_o[8] = I_PERIPH.csi1_data_out;
    O_PERIPH.csi1_data_in = on[7] & (pr7 == pam_pkg::SEL_A) & lv[7];
    O_PERIPH.timer_p2_capture_in_0 = on[7] &
      (pr7 == pam_pkg::SEL_B) & lv[7];
    p9_alt_oe[7] = pr7 == pam_pkg::SEL_C;
    p9_alt_o[7] = I_PERIPH.timer_p2_out_0;
    O_PERIPH.timer_p2_capture_in_1 = on[6] &
      (pr6 == pam_pkg::SEL_B) & lv[6];
    p9_alt_oe[6] = pr6 == pam_pkg::SEL_C;
    p9_alt_o[6] = I_PERIPH.timer_p2_out_1;
    // key return 7 shares the receive pin in both settings
    O_PERIPH.key_return_in_7 = on[1] & ((pr1 == pam_pkg::SEL_A) |
      (pr1 == pam_pkg::SEL_B)) & lv[1];
    O_PERIPH.async1_receive_in = on[1] & (pr1 == pam_pkg::SEL_B) & lv[1];
    O_PERIPH.key_return_in_6 = on[0] & (pr0 == pam_pkg::SEL_A) & lv[0];
    p9_alt_oe[0] = pr0 == pam_pkg::SEL_B;
    p9_alt_o[0] = I_PERIPH.async1_transmit_out;
    // bus control port
    cm_alt_o = 4'h0;
    cm_alt_oe = 4'h0;
    O_PERIPH.wait_in = bus_q[pam_pkg::CM_WAIT] &
      cm_s2_q[pam_pkg::CM_WAIT];
    O_PERIPH.hold_request_in = bus_q[pam_pkg::CM_HREQ] &
      cm_s2_q[pam_pkg::CM_HREQ];
    cm_alt_oe[pam_pkg::CM_CLK] = 1'b1;
    cm_alt_o[pam_pkg::CM_CLK] = I_PERIPH.clock_output;
    cm_alt_oe[pam_pkg::CM_HACK] = 1'b1;
    cm_alt_o[pam_pkg::CM_HACK] = I_PERIPH.hold_acknowledge_out;
    // strobe port
    ct_alt_o = 8'h00;
    ct_alt_oe = 8'h00;
    ct_alt_oe[pam_pkg::CT_WRL] = 1'b1;
    ct_alt_o[pam_pkg::CT_WRL] = I_PERIPH.write_strobe_low;
    ct_alt_oe[pam_pkg::CT_WRH] = 1'b1;
    ct_alt_o[pam_pkg::CT_WRH] = I_PERIPH.write_strobe_high;
    ct_alt_oe[pam_pkg::CT_RD] = 1'b1;
    ct_alt_o[pam_pkg::CT_RD] = I_PERIPH.read_strobe_out;
    ct_alt_oe[pam_pkg::CT_ADDRESS_STROBE_OUT] = 1'b1;
    ct_alt_o[pam_pkg::CT_ADDRESS_STROBE_OUT] = I_PERIPH.address_strobe_out;
  end

  // output stages: port 9 with open drain, the others push-pull
  for (genvar i = 0; i < 16; i++) begin : g_p9
    pam_pin_cell u_cell (
      .i_clk(I_REF_CLK), .i_rstn(I_RSTN),
      .i_mode(mode_q[i]), .i_od(od_q[i]),
      .i_alt_o(p9_alt_o[i]), .i_alt_oe(p9_alt_oe[i]),
      .i_port_o(I_P9_PORT_OUT[i]), .i_port_oe(I_P9_PORT_OE[i]),
      .o_pin(O_P9_PIN[i]), .o_pin_oe(O_P9_PIN_OE[i])
    );
  end
  // per-pin direction comes from the port block in port mode
  for (genvar i = 0; i < 4; i++) begin : g_cm
    pam_pin_cell u_cell (
      .i_clk(I_REF_CLK), .i_rstn(I_RSTN),
      .i_mode(bus_q[i]), .i_od(1'b0),
      .i_alt_o(cm_alt_o[i]), .i_alt_oe(cm_alt_oe[i]),
      .i_port_o(I_CM_PORT_OUT[i]), .i_port_oe(I_CM_PORT_OE[i]),
      .o_pin(O_CM_PIN[i]), .o_pin_oe(O_CM_PIN_OE[i])
    );
  end
  for (genvar i = 0; i < 8; i++) begin : g_ct
    pam_pin_cell u_cell (
      .i_clk(I_REF_CLK), .i_rstn(I_RSTN),
      .i_mode(stb_q[i]), .i_od(1'b0),
      .i_alt_o(ct_alt_o[i]), .i_alt_oe(ct_alt_oe[i]),
      .i_port_o(I_CT_PORT_OUT[i]), .i_port_oe(I_CT_PORT_OE[i]),
      .o_pin(O_CT_PIN[i]), .o_pin_oe(O_CT_PIN_OE[i])
    );
  end

  // checks
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RSTN);

  sequence s_wait_then_take;
    req && O_AVS_WAITREQUEST ##1 req;
  endsequence

  bus_answer_a: assert property (s_wait_then_take |-> !O_AVS_WAITREQUEST)
    else $error("bus request not answered after one wait cycle");
  word_write_a: assert property (acc && I_AVS_WRITE &&
      a == pam_pkg::IDX_P9_FSEL && I_AVS_BYTEENABLE[1:0] == 2'b11 |=>
      fsel_q == ($past(I_AVS_WRITEDATA[15:0]) & pam_pkg::P9_MASK))
    else $error("16-bit write to function select lost");
  high_half_a: assert property (acc && I_AVS_WRITE &&
      a == pam_pkg::IDX_P9_OD + pam_pkg::IDX_HI_STEP &&
      I_AVS_BYTEENABLE[0] |=> od_q[15:8] ==
      ($past(I_AVS_WRITEDATA[7:0]) & pam_pkg::P9_MASK[15:8]) &&
      $stable(od_q[7:0]))
    else $error("high half write misplaced");
  reserved_zero_a: assert property (((fext_q & ~pam_pkg::P9_EXT_MASK) |
      (fsel_q & ~pam_pkg::P9_MASK)) == 16'h0000)
    else $error("unimplemented select bit holds a one");
  timer_out_a: assert property (mode_q[15] &&
      pr15 == pam_pkg::SEL_C && !od_q[15] |=> O_P9_PIN_OE[15] &&
      O_P9_PIN[15] == $past(I_PERIPH.timer_p5_out_0))
    else $error("pin 15 timer output not driven");
  irq_path_a: assert property ((mode_q[15] &&
      pr15 == pam_pkg::SEL_A) [*3] |->
      O_PERIPH.ext_irq_in_6 == $past(I_P9_PIN[15], 2))
    else $error("pin 15 interrupt input not delivered");
  rx_share_a: assert property (mode_q[1] &&
      pr1 == pam_pkg::SEL_B |->
      O_PERIPH.async1_receive_in == O_PERIPH.key_return_in_7)
    else $error("receive and key return 7 disagree");
  prohibit_a: assert property (mode_q[pam_pkg::PIN_TP21] &&
      !pr6[1] |=> !O_P9_PIN_OE[pam_pkg::PIN_TP21])
    else $error("prohibited selection drives pin 6");
  open_drain_a: assert property (((O_P9_PIN_OE & O_P9_PIN &
      $past(od_q)) == 16'h0000))
    else $error("open-drain pin driven high");
  clock_out_a: assert property (bus_q[pam_pkg::CM_CLK] |=>
      O_CM_PIN_OE[pam_pkg::CM_CLK] && O_CM_PIN[pam_pkg::CM_CLK] ==
      $past(I_PERIPH.clock_output))
    else $error("clock output not on its pin");
  strobe_out_a: assert property (stb_q[pam_pkg::CT_ADDRESS_STROBE_OUT] |=>
      O_CT_PIN_OE[pam_pkg::CT_ADDRESS_STROBE_OUT] && O_CT_PIN[pam_pkg::CT_ADDRESS_STROBE_OUT] ==
      $past(I_PERIPH.address_strobe_out))
    else $error("address strobe not on its pin");
  mode_read_a: assert property (acc && I_AVS_READ &&
      a == pam_pkg::IDX_STB_MODE |-> O_AVS_READDATA[31:7] == 25'h0 &&
      O_AVS_READDATA[5] == 1'b0 && O_AVS_READDATA[3:2] == 2'b00)
    else $error("unimplemented strobe mode bit read as one");
endmodule

// file: test/pam_far_side.sv
/*
 pam_far_side: peripherals and board seen from the pin multiplexer.
 Assumes the bench sets peripheral outputs and external pin levels.
*/
`timescale 1ns/1ps
module pam_far_side (
  // design pin drive
  input wire logic [15:0] i_p9_pin,
  input wire logic [15:0] i_p9_oe,
  input wire logic [3:0] i_cm_pin,
  input wire logic [3:0] i_cm_oe,
  input wire logic [7:0] i_ct_pin,
  input wire logic [7:0] i_ct_oe,
  // board levels and peripheral outputs
  input wire logic [15:0] i_p9_ext,
  input wire logic [3:0] i_cm_ext,
  input wire logic [7:0] i_ct_ext,
  input wire pam_pkg::pam_to_pin_s i_periph_set,
  // toward the design
  output pam_pkg::pam_to_pin_s o_periph,
  output logic [15:0] o_p9_wire,
  output logic [3:0] o_cm_wire,
  output logic [7:0] o_ct_wire
);
  assign o_periph = i_periph_set;
  // released pins go to the board level, a pull-up by default
  assign o_p9_wire = (i_p9_oe & i_p9_pin) | (~i_p9_oe & i_p9_ext);
  assign o_cm_wire = (i_cm_oe & i_cm_pin) | (~i_cm_oe & i_cm_ext);
  assign o_ct_wire = (i_ct_oe & i_ct_pin) | (~i_ct_oe & i_ct_ext);
endmodule

// file: test/tb_top.sv
/*
 tb_top: register and pin-mux tests for pam_port_mux over Avalon-MM.
 Assumes pam_far_side resolves pins and feeds peripheral outputs.
*/
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] adr = 32'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [3:0] be = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq;
  logic [15:0] p9_out = 16'h0;
  logic [15:0] p9_oe = 16'h0;
  logic [15:0] p9_ext = 16'hFFFF;
  logic [3:0] cm_ext = 4'hF;
  logic [7:0] ct_ext = 8'hFF;
  pam_pkg::pam_to_pin_s per = '0;
  pam_pkg::pam_to_pin_s per_w;
  pam_pkg::pam_from_pin_s pin_in;
  logic [15:0] p9_o, p9_oq, p9_w;
  logic [3:0] cm_o, cm_oq, cm_w;
  logic [7:0] ct_o, ct_oq, ct_w;
  logic [15:0] p9_lv;
  logic [3:0] cm_lv;
  logic [7:0] ct_lv;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] q;
  logic v;
  logic [31:0] idx [6] = '{pam_pkg::IDX_P9_MODE, pam_pkg::IDX_P9_FSEL,
    pam_pkg::IDX_P9_FEXT, pam_pkg::IDX_P9_OD, pam_pkg::IDX_BUS_MODE,
    pam_pkg::IDX_STB_MODE};

  initial begin
    forever #2.5 clk = ~clk;
  end

  pam_port_mux pam_port_mux_inst (.I_REF_CLK(clk), .I_RSTN(rstn),
    .I_AVS_ADDRESS(adr), .I_AVS_READ(rd_en), .I_AVS_WRITE(wr_en),
    .I_AVS_BYTEENABLE(be), .I_AVS_WRITEDATA(wdat), .O_AVS_READDATA(rdat),
    .O_AVS_WAITREQUEST(wreq), .I_P9_PORT_OUT(p9_out), .I_P9_PORT_OE(p9_oe),
    .I_CM_PORT_OUT(p9_out[3:0]), .I_CM_PORT_OE(p9_oe[3:0]),
    .I_CT_PORT_OUT(p9_out[7:0]), .I_CT_PORT_OE(p9_oe[7:0]),
    .I_PERIPH(per_w), .O_PERIPH(pin_in), .I_P9_PIN(p9_w), .O_P9_PIN(p9_o),
    .O_P9_PIN_OE(p9_oq), .I_CM_PIN(cm_w), .O_CM_PIN(cm_o),
    .O_CM_PIN_OE(cm_oq), .I_CT_PIN(ct_w), .O_CT_PIN(ct_o),
    .O_CT_PIN_OE(ct_oq), .O_P9_LEVEL(p9_lv), .O_CM_LEVEL(cm_lv),
    .O_CT_LEVEL(ct_lv));

  pam_far_side pam_far_side_inst (.i_p9_pin(p9_o), .i_p9_oe(p9_oq),
    .i_cm_pin(cm_o), .i_cm_oe(cm_oq), .i_ct_pin(ct_o), .i_ct_oe(ct_oq),
    .i_p9_ext(p9_ext), .i_cm_ext(cm_ext), .i_ct_ext(ct_ext),
    .i_periph_set(per), .o_periph(per_w), .o_p9_wire(p9_w),
    .o_cm_wire(cm_w), .o_ct_wire(ct_w));

  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [31:0] a,
      input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    be <= b;
    wr_en <= w;
    rd_en <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [31:0] a,
      input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'h3);
    chk(nm, e, q);
  endtask

  task automatic settle();
    repeat (4) @(posedge clk);
  endtask

  // selects before mode, reserved bits left zero
  task automatic cfg(input logic [15:0] fe, input logic [15:0] fs,
      input logic [15:0] md);
    bus(1'b1, pam_pkg::IDX_P9_MODE, 32'h0, 4'h3);
    bus(1'b1, pam_pkg::IDX_P9_FEXT, 32'(fe), 4'h3);
    bus(1'b1, pam_pkg::IDX_P9_FSEL, 32'(fs), 4'h3);
    bus(1'b1, pam_pkg::IDX_P9_MODE, 32'(md), 4'h3);
    settle();
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    foreach (idx[i]) rdchk("reset value", idx[i], 32'h0);
    bus(1'b1, pam_pkg::IDX_P9_FSEL, 32'hE3C3, 4'h3);
    rdchk("fsel word", pam_pkg::IDX_P9_FSEL, 32'hE3C3);
    bus(1'b1, pam_pkg::IDX_P9_FSEL + 1, 32'hA0, 4'h1);
    rdchk("fsel high", pam_pkg::IDX_P9_FSEL, 32'hA0C3);
    rdchk("fsel half", pam_pkg::IDX_P9_FSEL + 1, 32'hA0);
    bus(1'b1, pam_pkg::IDX_P9_FSEL, 32'hE000, 4'h1);
    rdchk("fsel lane", pam_pkg::IDX_P9_FSEL, 32'hA000);
    bus(1'b1, pam_pkg::IDX_P9_FEXT, 32'hC0C3, 4'h3);
    rdchk("fext word", pam_pkg::IDX_P9_FEXT, 32'hC0C3);
    bus(1'b1, pam_pkg::IDX_BUS_MODE, 32'hFF, 4'h1);
    rdchk("bus mode", pam_pkg::IDX_BUS_MODE, 32'h0F);
    bus(1'b1, pam_pkg::IDX_STB_MODE, 32'hFF, 4'h1);
    rdchk("strobe mode", pam_pkg::IDX_STB_MODE, 32'h53);
    bus(1'b1, 32'h100, 32'hFFFF, 4'h3);
    rdchk("unmapped", 32'h100, 32'h0);
    per.csi1_clock_oe <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      v = k[0];
      per.clock_output <= v;
      per.hold_acknowledge_out <= !v;
      per.address_strobe_out <= v;
      per.read_strobe_out <= !v;
      per.write_strobe_high <= v;
      per.write_strobe_low <= !v;
      cm_ext <= {v, 2'b00, !v};
      settle();
      chk("bus port", 32'({v, !v, v, !v}), 32'({pin_in.hold_request_in,
        cm_w[2], cm_w[1], pin_in.wait_in}));
      chk("bus port oe", 32'h6, 32'(cm_oq));
      chk("strobes", 32'({v, !v, v, !v}),
        32'({ct_w[6], ct_w[4], ct_w[1], ct_w[0]}));
    end
    cfg(16'hC0C1, 16'hC3C0, 16'hC3C1);
    for (int k = 0; k < 2; k++) begin
      v = k[0];
      per.timer_p5_out_0 <= v;
      per.timer_p5_out_1 <= !v;
      per.timer_p2_out_0 <= v;
      per.timer_p2_out_1 <= !v;
      per.csi1_data_out <= v;
      per.csi1_clock_out <= !v;
      per.async1_transmit_out <= v;
      settle();
      chk("p9 alt out", 32'({v, !v, 4'h0, !v, v, v, !v, 5'h0, v}),
        32'(p9_w & 16'hC3C1));
      chk("p9 alt oe", 32'hC3C1, 32'(p9_oq & 16'hC3C1));
    end
    bus(1'b1, pam_pkg::IDX_P9_OD, 32'h41, 4'h3);
    for (int k = 0; k < 2; k++) begin
      v = k[0];
      per.async1_transmit_out <= v;
      per.timer_p2_out_1 <= !v;
      settle();
      chk("open drain", 32'({v, !v, !v, v}),
        32'({p9_oq[6], p9_oq[0], p9_w[6], p9_w[0]}));
    end
    bus(1'b1, pam_pkg::IDX_P9_OD + 1, 32'hE3, 4'h1);
    rdchk("od high", pam_pkg::IDX_P9_OD, 32'hE341);
    bus(1'b1, pam_pkg::IDX_P9_OD, 32'h0, 4'h3);
    cfg(16'h80C2, 16'h6000, 16'hE0C2);
    for (int k = 0; k < 2; k++) begin
      v = k[0];
      p9_ext <= {16{v}};
      settle();
      chk("p9 in a", 32'({{7{v}}, 2'b00}), 32'({
        pin_in.timer_p5_capture_in_0, pin_in.ext_irq_in_5,
        pin_in.ext_irq_in_4, pin_in.timer_p2_capture_in_0,
        pin_in.async1_receive_in, pin_in.key_return_in_7,
        pin_in.timer_p2_capture_in_1, pin_in.ext_irq_in_6,
        pin_in.csi1_data_in}));
      chk("p9 in a oe", 32'h0, 32'(p9_oq & 16'hE0C2));
    end
    per.csi1_clock_oe <= 1'b0;
    cfg(16'h4000, 16'h82C3, 16'hC2C3);
    for (int k = 0; k < 2; k++) begin
      v = k[0];
      p9_ext <= {16{v}};
      settle();
      chk("p9 in b", 32'({{6{v}}, 2'b00}), 32'({pin_in.ext_irq_in_6,
        pin_in.csi1_data_in, pin_in.key_return_in_6,
        pin_in.key_return_in_7, pin_in.timer_p5_capture_in_1,
        pin_in.csi1_clock_in, pin_in.async1_receive_in,
        pin_in.timer_p5_capture_in_0}));
      chk("p9 in b oe", 32'h0, 32'(p9_oq & 16'hC2C3));
    end
    cfg(16'h0, 16'h0, 16'h0);
    bus(1'b1, pam_pkg::IDX_BUS_MODE, 32'h0, 4'h1);
    bus(1'b1, pam_pkg::IDX_STB_MODE, 32'h0, 4'h1);
    p9_out <= 16'hA5A5;
    p9_oe <= 16'hFFFF;
    settle();
    chk("port mode", 32'({16'hA5A5, 4'h5, 8'hA5}),
      32'({p9_w, cm_w, ct_w}));
    chk("levels", 32'({16'hA5A5, 4'h5, 8'hA5}),
      32'({p9_lv, cm_lv, ct_lv}));
    test_done();
  end
endmodule
